// ### bzm_params.svh
`ifndef BZM_PARAMS_SVH
`define BZM_PARAMS_SVH
// register indices, not byte addresses (printed offsets are not multiples of 4: index*4)
`define BZM_IDX_MUX_CONFIG       8'h41
`define BZM_IDX_LOADING_CONFIG   8'h42
`define BZM_IDX_ELECTRODE_ASSIGN 8'h43
`define BZM_IDX_SELFTEST_ERROR   8'h44
`define BZM_IDX_DC_LEAD_CONFIG   8'h50
`define BZM_IDX_MODE_CONFIG      8'h60
`define BZM_IDX_STATUS           8'h61
`define BZM_ADDR_W               10
// field positions
`define BZM_MUX_EN_BIT           1
`define BZM_CAL_EN_BIT           0
`define BZM_CAL_ONLY_BIT         2
`define BZM_INLOAD_BIT           0
`define BZM_PSENSE_LSB           6
`define BZM_NSENSE_LSB           4
`define BZM_PDRIVE_LSB           2
`define BZM_NDRIVE_LSB           0
`define BZM_LON_BIT              7
`define BZM_LOFF_BIT             6
`define BZM_EXT_LOFF_BIT         5
`define BZM_OOR_EN_BIT           4
`define BZM_IPOL_BIT             3
`define BZM_IMAG_LSB             0
`define BZM_IEN_BIT              2
`define BZM_QEN_BIT              3
`define BZM_OOR_FLAG_BIT         4
// reset values
`define BZM_RST_BYTE             8'h00
`define BZM_SELFTEST_TRIM        8'h00
`endif

// ### bzm_pkg.sv
package bzm_pkg;
  typedef enum logic [1:0] {
    BZM_SEL_OUTER = 2'h0,
    BZM_SEL_A     = 2'h1,
    BZM_SEL_B     = 2'h2,
    BZM_SEL_RSVD  = 2'h3
  } bzm_sel_t;
  typedef enum logic [1:0] {
    BZM_DRV_CURRENT = 2'h0,
    BZM_DRV_VOLTAGE = 2'h1,
    BZM_DRV_HBRIDGE = 2'h2,
    BZM_DRV_CUR_ALT = 2'h3
  } bzm_drv_mode_t;
  // one-hot pin connect vector: outer, inner a, inner b
  typedef logic [2:0] bzm_pins_t;
endpackage

// ### bzm_regs.sv
// Behaviour
// R1 - inload bit 1 enables input capacitive loading compensation, 0 disables
// R2 - assign register: psense 7:6, nsense 5:4, pdrive 3:2, ndrive 1:0
// R3 - psense code 0 outer, 1 inner a, 2 inner b, 3 reserved
// R4 - assignments act only with mux enabled; calibration disconnects electrodes
// R5 - nsense code 0 outer, 1 inner a, 2 inner b, 3 reserved
// R6 - current modes 0/3: pdrive code picks outer, inner a, inner b
// R7 - voltage or h-bridge mode: pdrive always on outer positive electrode
// R8 - current modes 0/3: ndrive code picks outer, inner a, inner b
// R9 - voltage or h-bridge mode: ndrive always on outer negative electrode
// R10 - software should use outer electrodes for drive at 64 uA or more
// R11 - self-test error register is 8-bit read-only two's complement trim
// R12 - software scales nominal resistance by one plus error over 512
// R13 - dc lead register: lon 7, loff 6, ext 5, oor 4, pol 3, mag 2:0
// R14 - lead-on detection runs only when enabled and both i and q off
// R15 - lead-off detection runs when enabled and i or q on
// R16 - external lead-off moves monitoring from sense nodes to inner b pins
// R17 - range monitor sets sticky out-of-range flag on large drive voltage
// R18 - polarity 0: positive sources, negative sinks; 1 inverted
// R19 - mux enable 0 disconnects every electrode and calibration pin
// R20 - writes to the self-test error register are ignored
// R21 - reserved code 3 is stored, read back, connects nothing
//
// Register access over Avalon-MM was decided locally.
`include "bzm_params.svh"
module bzm_regs (
  input  wire logic                     core_clk_i,
  input  wire logic                     resetn_i,
  input  wire logic                     clk_en_i,
  input  wire logic [`BZM_ADDR_W-1:0]   avs_address_i,
  input  wire logic                     avs_read_i,
  input  wire logic                     avs_write_i,
  input  wire logic [31:0]              avs_writedata_i,
  input  wire logic [3:0]               avs_byteenable_i,
  output logic      [31:0]              avs_readdata_o,
  output logic                          avs_waitrequest_o,
  output logic      [1:0]               avs_response_o,
  input  wire logic                     drive_large_i,
  output logic                          input_loading_comp_enable_o,
  output bzm_pkg::bzm_pins_t            pos_sense_pins_o,
  output bzm_pkg::bzm_pins_t            neg_sense_pins_o,
  output bzm_pkg::bzm_pins_t            pos_drive_pins_o,
  output bzm_pkg::bzm_pins_t            neg_drive_pins_o,
  output logic                          cal_pins_connect_o,
  output logic                          lead_on_detect_active_o,
  output logic                          lead_off_detect_active_o,
  output logic                          lead_off_on_inner_b_o,
  output logic                          drive_range_monitor_active_o,
  output logic                          lead_off_current_polarity_o,
  output logic      [2:0]               lead_off_current_magnitude_o,
  output logic                          drive_out_of_range_flag_o
);
  import bzm_pkg::*;

  logic [7:0]  mux_cfg;
  logic [7:0]  load_cfg;
  logic [7:0]  assign_reg;
  logic [7:0]  dc_cfg;
  logic [7:0]  mode_cfg;
  logic        oor_flag;
  logic        drv_sync1;
  logic        drv_sync2;
  logic        ack;
  logic        wait_q;
  logic [31:0] rdata;
  logic [1:0]  resp;
  logic [7:0]  next_mux_cfg;
  logic [7:0]  next_load_cfg;
  logic [7:0]  next_assign_reg;
  logic [7:0]  next_dc_cfg;
  logic [7:0]  next_mode_cfg;
  logic        next_oor_flag;
  logic        next_ack;
  logic        next_wait;
  logic [31:0] next_rdata;
  logic [1:0]  next_resp;
  logic [7:0]  idx;
  logic        req;
  logic        wr;
  logic        mapped;
  logic        sel_mux;
  logic        sel_load;
  logic        sel_assign;
  logic        sel_trim;
  logic        sel_dc;
  logic        sel_mode;
  logic        sel_status;

  // one wait cycle: take on the first edge, answer on the second
  assign idx = avs_address_i[9:2];
  assign req = (avs_read_i | avs_write_i) & ~ack;
  // write lands at the answer edge, while the master still holds it
  assign wr  = avs_write_i & avs_byteenable_i[0] & ack;

  // one decode per mapped register
  assign sel_mux    = (idx == `BZM_IDX_MUX_CONFIG);
  assign sel_load   = (idx == `BZM_IDX_LOADING_CONFIG);
  assign sel_assign = (idx == `BZM_IDX_ELECTRODE_ASSIGN);
  assign sel_trim   = (idx == `BZM_IDX_SELFTEST_ERROR);
  assign sel_dc     = (idx == `BZM_IDX_DC_LEAD_CONFIG);
  assign sel_mode   = (idx == `BZM_IDX_MODE_CONFIG);
  assign sel_status = (idx == `BZM_IDX_STATUS);
  // unmapped indices answer with a slave error instead of hanging the bus
  assign mapped = sel_mux | sel_load | sel_assign | sel_trim |
                  sel_dc | sel_mode | sel_status;

  always_comb begin
    next_mux_cfg    = mux_cfg;
    next_load_cfg   = load_cfg;
    next_assign_reg = assign_reg;
    next_dc_cfg     = dc_cfg;
    next_mode_cfg   = mode_cfg;
    next_ack        = req;
    next_wait       = ~req;
    next_resp       = 2'h0;
    next_rdata      = 32'h0000_0000;
    if (wr) begin
      unique case (idx)
        `BZM_IDX_MUX_CONFIG:       next_mux_cfg = avs_writedata_i[7:0];
        `BZM_IDX_LOADING_CONFIG:   next_load_cfg = avs_writedata_i[7:0];
        // reserved code 3 is kept as written; see R2 see R21
        `BZM_IDX_ELECTRODE_ASSIGN: next_assign_reg = avs_writedata_i[7:0];
        // see R13
        `BZM_IDX_DC_LEAD_CONFIG:   next_dc_cfg = avs_writedata_i[7:0];
        `BZM_IDX_MODE_CONFIG:      next_mode_cfg = avs_writedata_i[7:0];
        default: ; // trim and status are read-only; see R20
      endcase
    end
    if (req) begin
      if (!mapped)
        next_resp = 2'h2;
      if (avs_read_i) begin
        unique case (idx)
          `BZM_IDX_MUX_CONFIG:       next_rdata[7:0] = mux_cfg;
          `BZM_IDX_LOADING_CONFIG:   next_rdata[7:0] = load_cfg;
          `BZM_IDX_ELECTRODE_ASSIGN: next_rdata[7:0] = assign_reg;
          `BZM_IDX_SELFTEST_ERROR:   // see R11
            next_rdata[7:0] = `BZM_SELFTEST_TRIM;
          `BZM_IDX_DC_LEAD_CONFIG:   next_rdata[7:0] = dc_cfg;
          `BZM_IDX_MODE_CONFIG:      next_rdata[7:0] = mode_cfg;
          `BZM_IDX_STATUS:
            next_rdata[`BZM_OOR_FLAG_BIT] = oor_flag;
          default: ;
        endcase
      end
    end
  end

  // sticky flag; a new event wins over the read-to-clear
  always_comb begin
    next_oor_flag = oor_flag;
    if (req && avs_read_i && idx == `BZM_IDX_STATUS)
      next_oor_flag = 1'b0;
    if (dc_cfg[`BZM_OOR_EN_BIT] && drv_sync2)
      next_oor_flag = 1'b1; // see R17
  end

  // two-flop synchroniser: only the second stage is read by logic
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      drv_sync1 <= 1'b0;
      drv_sync2 <= 1'b0;
    end else if (clk_en_i) begin
      drv_sync1 <= drive_large_i;
      drv_sync2 <= drv_sync1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      oor_flag <= 1'b0;
    end else if (clk_en_i) begin
      oor_flag <= next_oor_flag;
    end
  end

  // clk_en low also freezes a pending answer
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      mux_cfg    <= `BZM_RST_BYTE;
      load_cfg   <= `BZM_RST_BYTE;
      assign_reg <= `BZM_RST_BYTE;
      dc_cfg     <= `BZM_RST_BYTE;
      mode_cfg   <= `BZM_RST_BYTE;
      ack        <= 1'b0;
      wait_q     <= 1'b1;
      rdata      <= 32'h0000_0000;
      resp       <= 2'h0;
    end else if (clk_en_i) begin
      mux_cfg    <= next_mux_cfg;
      load_cfg   <= next_load_cfg;
      assign_reg <= next_assign_reg;
      dc_cfg     <= next_dc_cfg;
      mode_cfg   <= next_mode_cfg;
      ack        <= next_ack;
      wait_q     <= next_wait;
      rdata      <= next_rdata;
      resp       <= next_resp;
    end
  end

  // waitrequest high except in the answer cycle, kept in its own flop
  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o    = rdata;
  assign avs_response_o    = resp;

  // electrode routing
  function automatic bzm_pins_t decode_sel(input logic [1:0] code);
    unique case (bzm_sel_t'(code))
      BZM_SEL_OUTER: decode_sel = 3'b001;
      BZM_SEL_A:     decode_sel = 3'b010;
      BZM_SEL_B:     decode_sel = 3'b100;
      default:       decode_sel = 3'b000; // see R21
    endcase
  endfunction

  bzm_pins_t     next_psense;
  bzm_pins_t     next_nsense;
  bzm_pins_t     next_pdrive;
  bzm_pins_t     next_ndrive;
  logic          next_cal;
  logic          el_on;
  logic          fixed_drv;
  logic          meas_on;
  bzm_drv_mode_t drv_mode;

  logic          next_lon;
  logic          next_loff;
  logic          next_ext;
  logic          next_oor_act;
  logic          next_inload;
  logic          next_ipol;
  logic [2:0]    next_imag;
  logic          next_oor_out;

  always_comb begin
    drv_mode = bzm_drv_mode_t'(mode_cfg[1:0]);
    fixed_drv = (drv_mode == BZM_DRV_VOLTAGE) ||
                (drv_mode == BZM_DRV_HBRIDGE);
    // calibration drops electrodes entirely; see R4 see R19
    el_on = mux_cfg[`BZM_MUX_EN_BIT] & ~mux_cfg[`BZM_CAL_EN_BIT];
    next_cal = mux_cfg[`BZM_MUX_EN_BIT] & mux_cfg[`BZM_CAL_EN_BIT]; // see R19
    next_psense = 3'b000;
    next_nsense = 3'b000;
    next_pdrive = 3'b000;
    next_ndrive = 3'b000;
    // all four nodes stay open unless the electrodes are switched in
    if (el_on) begin
      next_psense = decode_sel(assign_reg[7:6]); // see R3
      next_nsense = decode_sel(assign_reg[5:4]); // see R5
      // drive mode 3 routes like current mode 0
      if (fixed_drv) begin
        next_pdrive = 3'b001; // see R7
        next_ndrive = 3'b001; // see R9
      end else begin
        next_pdrive = decode_sel(assign_reg[3:2]); // see R6
        next_ndrive = decode_sel(assign_reg[1:0]); // see R8
      end
    end
    meas_on   = mode_cfg[`BZM_IEN_BIT] | mode_cfg[`BZM_QEN_BIT];
    next_lon  = dc_cfg[`BZM_LON_BIT] & ~meas_on; // see R14
    next_loff = dc_cfg[`BZM_LOFF_BIT] & meas_on; // see R15
    next_ext  = dc_cfg[`BZM_EXT_LOFF_BIT]; // see R16
    next_oor_act = dc_cfg[`BZM_OOR_EN_BIT];
    next_inload  = load_cfg[`BZM_INLOAD_BIT]; // see R1
    next_ipol    = dc_cfg[`BZM_IPOL_BIT]; // see R18
    next_imag    = dc_cfg[`BZM_IMAG_LSB +: 3];
    next_oor_out = oor_flag;
  end

  // outputs registered: one cycle after the register write
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      input_loading_comp_enable_o  <= 1'b0;
      pos_sense_pins_o             <= 3'b000;
      neg_sense_pins_o             <= 3'b000;
      pos_drive_pins_o             <= 3'b000;
      neg_drive_pins_o             <= 3'b000;
      cal_pins_connect_o           <= 1'b0;
      lead_on_detect_active_o      <= 1'b0;
      lead_off_detect_active_o     <= 1'b0;
      lead_off_on_inner_b_o        <= 1'b0;
      drive_range_monitor_active_o <= 1'b0;
      lead_off_current_polarity_o  <= 1'b0;
      lead_off_current_magnitude_o <= 3'h0;
      drive_out_of_range_flag_o    <= 1'b0;
    end else if (clk_en_i) begin
      input_loading_comp_enable_o  <= next_inload;
      pos_sense_pins_o             <= next_psense;
      neg_sense_pins_o             <= next_nsense;
      pos_drive_pins_o             <= next_pdrive;
      neg_drive_pins_o             <= next_ndrive;
      cal_pins_connect_o           <= next_cal;
      lead_on_detect_active_o      <= next_lon;
      lead_off_detect_active_o     <= next_loff;
      lead_off_on_inner_b_o        <= next_ext;
      drive_range_monitor_active_o <= next_oor_act;
      lead_off_current_polarity_o  <= next_ipol;
      lead_off_current_magnitude_o <= next_imag;
      drive_out_of_range_flag_o    <= next_oor_out;
    end
  end
endmodule // bzm_regs

// ### bzm_regs_props.sv
`include "bzm_params.svh"
module bzm_regs_props (
  input logic               core_clk_i,
  input logic               resetn_i,
  input logic               clk_en_i,
  input logic [9:0]         avs_address_i,
  input logic               avs_read_i,
  input logic               avs_write_i,
  input logic [31:0]        avs_writedata_i,
  input logic [3:0]         avs_byteenable_i,
  input logic [31:0]        avs_readdata_o,
  input logic               avs_waitrequest_o,
  input logic               drive_large_i,
  input bzm_pkg::bzm_pins_t pos_sense_pins_o,
  input bzm_pkg::bzm_pins_t neg_sense_pins_o,
  input bzm_pkg::bzm_pins_t pos_drive_pins_o,
  input bzm_pkg::bzm_pins_t neg_drive_pins_o,
  input logic               cal_pins_connect_o,
  input logic               lead_on_detect_active_o,
  input logic               lead_off_detect_active_o,
  input logic               lead_off_on_inner_b_o,
  input logic               drive_range_monitor_active_o,
  input logic               lead_off_current_polarity_o,
  input logic [2:0]         lead_off_current_magnitude_o,
  input logic               drive_out_of_range_flag_o
);
  import bzm_pkg::*;
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);
  sequence take_s;
    (avs_read_i || avs_write_i) && avs_waitrequest_o && clk_en_i;
  endsequence
  sequence dc_wr_s;
    take_s ##0 (avs_write_i && avs_byteenable_i[0]
      && avs_address_i[9:2] == 8'h50) ##1 clk_en_i ##1 clk_en_i;
  endsequence
  take_answer_a: assert property (take_s |=> !avs_waitrequest_o)
    else $error("request not answered one cycle later");
  answer_pulse_a: assert property (!avs_waitrequest_o && clk_en_i
    |=> avs_waitrequest_o) else $error("answer held too long");
  trim_read_a: assert property (!avs_waitrequest_o && $past(avs_read_i)
    && $past(avs_address_i[9:2]) == 8'h44
    |-> avs_readdata_o == {24'h0, `BZM_SELFTEST_TRIM})
    else $error("trim value read back wrong");
  cal_disc_a: assert property (cal_pins_connect_o |-> (pos_sense_pins_o
    | neg_sense_pins_o | pos_drive_pins_o | neg_drive_pins_o) == 3'h0)
    else $error("electrode connected during calibration");
  pins_onehot_a: assert property ($onehot0(pos_sense_pins_o)
    && $onehot0(neg_sense_pins_o) && $onehot0(pos_drive_pins_o)
    && $onehot0(neg_drive_pins_o)) else $error("two pins on one node");
  detect_excl_a: assert property (!(lead_on_detect_active_o
    && lead_off_detect_active_o)) else $error("lead-on and lead-off both on");
  dc_cfg_a: assert property (dc_wr_s |=> {lead_off_on_inner_b_o,
    drive_range_monitor_active_o, lead_off_current_polarity_o,
    lead_off_current_magnitude_o} == $past(avs_writedata_i[5:0], 3))
    else $error("lead config outputs do not follow write");
  oor_set_a: assert property ((drive_range_monitor_active_o
    && drive_large_i && clk_en_i) [*4] |=> drive_out_of_range_flag_o)
    else $error("out-of-range flag not raised");
  oor_gate_a: assert property ($rose(drive_out_of_range_flag_o)
    |-> $past(drive_range_monitor_active_o))
    else $error("flag raised with monitor off");
endmodule // bzm_regs_props

// ### bzm_regs_test.sv
module bzm_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk_i, resetn_i, clk_en_i, drive_large_i;
  logic        avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [9:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic [3:0]  avs_byteenable_i;
  logic [1:0]  avs_response_o, r;
  logic [2:0]  pos_sense_pins_o, neg_sense_pins_o, pos_drive_pins_o;
  logic [2:0]  neg_drive_pins_o, lead_off_current_magnitude_o;
  logic        input_loading_comp_enable_o, cal_pins_connect_o;
  logic        lead_on_detect_active_o, lead_off_detect_active_o;
  logic        lead_off_on_inner_b_o, drive_range_monitor_active_o;
  logic        lead_off_current_polarity_o, drive_out_of_range_flag_o;
  logic [7:0]  mx, md, asg, dc;
  logic        on, dm;
  int          failures, samples_checked, cycles;
  bzm_regs i_dut (.core_clk_i, .resetn_i, .clk_en_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
    .avs_readdata_o, .avs_waitrequest_o, .avs_response_o, .drive_large_i,
    .input_loading_comp_enable_o, .pos_sense_pins_o, .neg_sense_pins_o,
    .pos_drive_pins_o, .neg_drive_pins_o, .cal_pins_connect_o,
    .lead_on_detect_active_o, .lead_off_detect_active_o,
    .lead_off_on_inner_b_o, .drive_range_monitor_active_o,
    .lead_off_current_polarity_o, .lead_off_current_magnitude_o,
    .drive_out_of_range_flag_o);
  always #50 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      close_out();
    end
  end
  task automatic close_out;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one idle edge after release keeps each drive to one change per step
  task automatic xfer(input logic wr, input logic [7:0] idx,
                      input logic [7:0] d);
    avs_address_i <= {idx, 2'h0};
    avs_writedata_i <= {24'h0, d};
    if (wr) avs_write_i <= 1'b1;
    else avs_read_i <= 1'b1;
    do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    r = avs_response_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] e,
                    input logic [1:0] er);
    xfer(1'b0, idx, 8'h00);
    chk(q, e);
    chk(r, er);
  endtask
  function automatic logic [2:0] pin(input logic [1:0] c, input logic en);
    pin = (en && c != 2'h3) ? 3'h1 << c : 3'h0;
  endfunction
  initial begin
    core_clk_i = 0; resetn_i = 0; clk_en_i = 1; drive_large_i = 0;
    avs_read_i = 0; avs_write_i = 0; avs_address_i = 0;
    avs_writedata_i = 0; avs_byteenable_i = 4'hF;
    void'($urandom(75));
    repeat (5) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    @(posedge core_clk_i);
    rd(8'h43, 32'h0, 2'h0);
    rd(8'h50, 32'h0, 2'h0);
    wr(8'h44, 8'hA5);
    rd(8'h44, 32'h0, 2'h0);
    rd(8'h45, 32'h0, 2'h2);
    $display("reset and access test done");
    for (int i = 0; i < 24; i++) begin
      mx = (i < 4) ? 8'(i) : 8'($urandom_range(0, 7));
      md = 8'($urandom_range(0, 15));
      asg = 8'($urandom);
      dc = 8'($urandom);
      wr(8'h41, mx);
      wr(8'h60, md);
      wr(8'h43, asg);
      wr(8'h50, dc);
      wr(8'h42, 8'(i & 1));
      @(posedge core_clk_i);
      on = mx[1] & ~mx[0];
      dm = md[1:0] inside {2'h1, 2'h2};
      chk(pos_sense_pins_o, pin(asg[7:6], on));
      chk(neg_sense_pins_o, pin(asg[5:4], on));
      chk(pos_drive_pins_o, pin(dm ? 2'h0 : asg[3:2], on));
      chk(neg_drive_pins_o, pin(dm ? 2'h0 : asg[1:0], on));
      chk(cal_pins_connect_o, mx[1] & mx[0]);
      chk(input_loading_comp_enable_o, i & 1);
      chk(lead_on_detect_active_o, dc[7] & ~(md[2] | md[3]));
      chk(lead_off_detect_active_o, dc[6] & (md[2] | md[3]));
      chk({lead_off_on_inner_b_o, drive_range_monitor_active_o,
        lead_off_current_polarity_o}, dc[5:3]);
      chk(lead_off_current_magnitude_o, dc[2:0]);
      rd(8'h43, asg, 2'h0);
      rd(8'h50, dc, 2'h0);
    end
    avs_byteenable_i <= 4'hE;
    wr(8'h43, ~asg);
    avs_byteenable_i <= 4'hF;
    rd(8'h43, asg, 2'h0);
    $display("routing test done");
    wr(8'h43, 8'h00);
    wr(8'h50, 8'h00);
    drive_large_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    chk(drive_out_of_range_flag_o, 1'b0);
    wr(8'h50, 8'h10);
    repeat (6) @(posedge core_clk_i);
    chk(drive_out_of_range_flag_o, 1'b1);
    drive_large_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    xfer(1'b0, 8'h61, 8'h00);
    chk(q[4], 1'b1);
    chk(drive_out_of_range_flag_o, 1'b0);
    clk_en_i <= 1'b0;
    fork
      begin
        repeat (4) @(posedge core_clk_i);
        clk_en_i <= 1'b1;
      end
    join_none
    rd(8'h50, 32'h10, 2'h0);
    $display("range monitor test done");
    close_out();
  end
endmodule // bzm_regs_test
bind bzm_regs bzm_regs_props i_props (.core_clk_i, .resetn_i, .clk_en_i,
  .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
  .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .drive_large_i,
  .pos_sense_pins_o, .neg_sense_pins_o, .pos_drive_pins_o,
  .neg_drive_pins_o, .cal_pins_connect_o, .lead_on_detect_active_o,
  .lead_off_detect_active_o, .lead_off_on_inner_b_o,
  .drive_range_monitor_active_o, .lead_off_current_polarity_o,
  .lead_off_current_magnitude_o, .drive_out_of_range_flag_o);
